// ===== hdl/spd_pkg.sv
/*
 * Shared constants and types for the setup-pin clock divider block.
 * Assumes setup pins arrive as 2-bit level codes (0, 1/3, 2/3, 1 -> 0..3) from a front end.
 */
package spd_pkg;

    // ****************************************
    // pin levels, pin count and output count
    // ****************************************
    localparam logic [1:0] SPD_LVL_0   = 2'h0;
    localparam logic [1:0] SPD_LVL_1_3 = 2'h1;
    localparam logic [1:0] SPD_LVL_2_3 = 2'h2;
    localparam logic [1:0] SPD_LVL_1   = 2'h3;
    localparam int         SPD_NUM_PINS = 11;
    localparam int         SPD_NUM_OUTS = 3;

    // ****************************************
    // widths and timing counts
    // ****************************************
    localparam int         SPD_RATIO_W     = 6;
    localparam int         SPD_PHASE_W     = 4;
    localparam logic [2:0] SPD_SYNC_CYCLES = 3'h4;
    localparam logic [5:0] SPD_RATIO_BYPASS = 6'h01;

    // ****************************************
    // divide ratio tables, index = low + 4 * high
    // ****************************************
    localparam logic [5:0] SPD_STD_RATIO [0:15] = '{
        6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h08, 6'h09,
        6'h0A, 6'h0C, 6'h0F, 6'h10, 6'h12, 6'h18, 6'h1E, 6'h20};
    localparam logic [5:0] SPD_ALT_RATIO [0:15] = '{
        6'h07, 6'h0B, 6'h0D, 6'h0E, 6'h11, 6'h13, 6'h14, 6'h15,
        6'h16, 6'h17, 6'h19, 6'h1A, 6'h1B, 6'h1C, 6'h1D, 6'h1F};

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [1:0] {
        SPD_HOLD = 2'b00,
        SPD_WAIT = 2'b01,
        SPD_RUN  = 2'b10
    } spd_div_mode_t;

    typedef struct packed {
        logic [SPD_RATIO_W-1:0] ratio;
        logic [SPD_PHASE_W-1:0] phase;
        logic                   enable;
        logic                   bypass;
    } spd_div_cfg_t;

    typedef struct packed {
        spd_div_mode_t          mode;
        logic [SPD_RATIO_W-1:0] cnt;
        logic [SPD_RATIO_W-1:0] wait_cnt;
        logic [SPD_RATIO_W-1:0] ratio;
        logic                   out;
    } spd_div_state_t;

    typedef struct packed {
        logic [SPD_NUM_PINS-1:0][1:0] pin_meta;
        logic [SPD_NUM_PINS-1:0][1:0] pin_stab;
        logic                         sync_meta;
        logic                         sync_stab;
        logic                         sync_prev;
        logic [2:0]                   rel_cnt;
        logic                         start;
        logic [SPD_NUM_OUTS-1:0]      enable;
        logic [SPD_NUM_OUTS-1:0]      bypass;
        logic [3:0]                   fine_word;
        logic                         fine_on;
        logic [1:0]                   delay_range;
        logic [1:0]                   level_sel;
    } spd_top_state_t;

endpackage : spd_pkg

// ===== hdl/spd_divider.sv
/*
 * One clock output divider with phase offset and sync hold.
 * Assumes hold and start come from logic on the same clock; start is a one-cycle pulse.
 */
`timescale 1ns/1ps
module spd_divider (
    // clock and reset
    input  wire logic          clk,
    input  wire logic          rst,
    // control
    input  spd_pkg::spd_div_cfg_t cfg,
    input  wire logic          hold,
    input  wire logic          start,
    // output
    output logic               out
);
    import spd_pkg::*;

    spd_div_state_t div_reg;
    spd_div_state_t div_next;
    logic [SPD_RATIO_W-1:0] high_time;

    always_comb begin
        div_next  = div_reg;
        high_time = {1'b0, div_reg.ratio[SPD_RATIO_W-1:1]};
        case (div_reg.mode)
            SPD_HOLD: begin
                div_next.out = 1'b0;
                if (start) begin
                    // ratio and phase only taken here, so their changes wait for a sync
                    div_next.ratio    = cfg.ratio;
                    div_next.wait_cnt = {2'h0, cfg.phase} % cfg.ratio;
                    div_next.mode     = SPD_WAIT;
                end
            end
            SPD_WAIT: begin
                if (div_reg.wait_cnt == '0) begin
                    div_next.mode = SPD_RUN;
                    div_next.cnt  = '0;
                    div_next.out  = 1'b1;
                end else begin
                    div_next.wait_cnt = div_reg.wait_cnt - 6'h01;
                end
            end
            SPD_RUN: begin
                div_next.cnt = (div_reg.cnt == div_reg.ratio - 6'h01) ? '0 : div_reg.cnt + 6'h01;
                div_next.out = (div_next.cnt < high_time);
            end
            default: begin
                div_next.mode = SPD_HOLD;
                div_next.out  = 1'b0;
            end
        endcase
        if (hold) begin
            div_next.mode = SPD_HOLD;
            div_next.out  = 1'b0;
        end
        // bypass marks the pass-through path; sync has no effect on it
        if (cfg.bypass) begin
            div_next.out = 1'b1;
        end
        if (!cfg.enable) begin
            div_next.out = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            div_reg <= '{mode: SPD_HOLD, cnt: '0, wait_cnt: '0, ratio: SPD_RATIO_BYPASS, out: 1'b0};
        end else begin
            div_reg <= div_next;
        end
    end

    assign out = div_reg.out;

endmodule : spd_divider

// ===== hdl/spd_top.sv
/*
 * Setup-pin decode and three clock dividers, phase offset on the second and third.
 * Assumes pins and the sync strobe are asynchronous and CLK is the fast input clock.
 */
`timescale 1ns/1ps

// Overview of operation
// - second and third outputs get 4-bit phase
// - pins 5/6: third ratio or second phase
// - pins 7/8: second ratio or third phase
// - pins 9/10: first ratio or third alt ratio
// - high time is floor of half ratio
// - wait phase cycles after sync release
// - phase steps are one input cycle each
// - phase wraps modulo the divide ratio
// - unique phases below ratio, max 15
// - sync low freezes; resume nine cycles later
// - ratio one bypasses divider, ignores sync
// - output-use pin disables at most one output
// - pins 3/4: third phase or fine delay
module spd_top (
    // clock and reset
    input  wire logic       CLK,
    input  wire logic       SYS_RST,
    // setup pins, level codes
    input  wire logic [1:0] DELAY_MODE_PIN,
    input  wire logic [1:0] OUTPUT_LEVEL_PIN,
    input  wire logic [1:0] OUTPUT_USE_PIN,
    input  wire logic [1:0] FINE_WORD_LOW_PIN,
    input  wire logic [1:0] FINE_WORD_HIGH_PIN,
    input  wire logic [1:0] SECOND_DIV_LOW_PIN,
    input  wire logic [1:0] SECOND_DIV_HIGH_PIN,
    input  wire logic [1:0] THIRD_DIV_LOW_PIN,
    input  wire logic [1:0] THIRD_DIV_HIGH_PIN,
    input  wire logic [1:0] FIRST_DIV_LOW_PIN,
    input  wire logic [1:0] FIRST_DIV_HIGH_PIN,
    // sync strobe
    input  wire logic       SYNC_REQUEST_N,
    // clock outputs
    output logic            CLOCK_OUTPUT_A,
    output logic            CLOCK_OUTPUT_B,
    output logic            CLOCK_OUTPUT_C,
    // output status
    output logic [2:0]      OUTPUT_ENABLE,
    output logic [2:0]      OUTPUT_BYPASS,
    // delay element control
    output logic [3:0]      FINE_DELAY_WORD,
    output logic            FINE_DELAY_ON,
    output logic [1:0]      DELAY_RANGE,
    output logic [1:0]      OUTPUT_LEVEL_SEL
);
    import spd_pkg::*;

    // ****************************************
    // state
    // ****************************************
    spd_top_state_t                 top_reg;
    spd_top_state_t                 top_next;
    logic [SPD_NUM_PINS-1:0][1:0]   pins_in;
    logic [1:0]                     use_lvl;
    logic [1:0]                     mode_lvl;
    logic [3:0]                     idx_34;
    logic [3:0]                     idx_56;
    logic [3:0]                     idx_78;
    logic [3:0]                     idx_910;
    spd_div_cfg_t [SPD_NUM_OUTS-1:0] cfg;
    logic [SPD_NUM_OUTS-1:0]        div_out;

    // element n of the bundle carries setup pin n
    assign pins_in = {FIRST_DIV_HIGH_PIN, FIRST_DIV_LOW_PIN, THIRD_DIV_HIGH_PIN, THIRD_DIV_LOW_PIN,
                      SECOND_DIV_HIGH_PIN, SECOND_DIV_LOW_PIN, FINE_WORD_HIGH_PIN, FINE_WORD_LOW_PIN,
                      OUTPUT_USE_PIN, OUTPUT_LEVEL_PIN, DELAY_MODE_PIN};

    // ****************************************
    // decode of the settled pin levels
    // ****************************************
    always_comb begin
        mode_lvl = top_reg.pin_stab[0];
        use_lvl  = top_reg.pin_stab[2];
        idx_34   = {top_reg.pin_stab[4], top_reg.pin_stab[3]};
        idx_56   = {top_reg.pin_stab[6], top_reg.pin_stab[5]};
        idx_78   = {top_reg.pin_stab[8], top_reg.pin_stab[7]};
        idx_910  = {top_reg.pin_stab[10], top_reg.pin_stab[9]};

        // unused settings park at ratio one with no phase
        for (int i = 0; i < SPD_NUM_OUTS; i++) begin
            cfg[i].ratio  = SPD_RATIO_BYPASS;
            cfg[i].phase  = 4'h0;
            cfg[i].enable = 1'b1;
        end

        // the output-use level decides what pin pairs 5/6, 7/8 and 9/10 mean
        case (use_lvl)
            SPD_LVL_0: begin
                cfg[0].ratio  = SPD_STD_RATIO[idx_910];
                cfg[1].ratio  = SPD_STD_RATIO[idx_78];
                cfg[1].phase  = idx_56;
                cfg[2].enable = 1'b0;
            end
            SPD_LVL_1_3: begin
                cfg[0].ratio = SPD_STD_RATIO[idx_910];
                cfg[1].ratio = SPD_STD_RATIO[idx_78];
                cfg[2].ratio = SPD_STD_RATIO[idx_56];
            end
            SPD_LVL_2_3: begin
                cfg[0].enable = 1'b0;
                cfg[1].ratio  = SPD_STD_RATIO[idx_78];
                cfg[2].ratio  = SPD_ALT_RATIO[idx_910];
            end
            SPD_LVL_1: begin
                cfg[0].ratio  = SPD_STD_RATIO[idx_910];
                cfg[1].enable = 1'b0;
                cfg[2].ratio  = SPD_STD_RATIO[idx_56];
                if (mode_lvl != SPD_LVL_0) begin
                    cfg[2].phase = idx_78;
                end
            end
            default: begin
                // unreachable for two-bit levels; park all outputs off
                cfg[0].enable = 1'b0;
                cfg[1].enable = 1'b0;
                cfg[2].enable = 1'b0;
            end
        endcase

        // with the delay element off its word pins steer the third phase
        if (mode_lvl == SPD_LVL_0) begin
            cfg[2].phase = idx_34;
        end

        // a disabled output keeps ratio one, so its bypass flag may read set
        for (int i = 0; i < SPD_NUM_OUTS; i++) begin
            cfg[i].bypass = (cfg[i].ratio == SPD_RATIO_BYPASS);
        end
    end

    // ****************************************
    // pin synchronisers, sync release timer, status
    // ****************************************
    always_comb begin
        top_next           = top_reg;
        top_next.pin_meta  = pins_in;
        top_next.pin_stab  = top_reg.pin_meta;
        top_next.sync_meta = SYNC_REQUEST_N;
        top_next.sync_stab = top_reg.sync_meta;
        top_next.sync_prev = top_reg.sync_stab;

        // a new low during the countdown restarts the whole sequence
        if (!top_reg.sync_stab) begin
            top_next.rel_cnt = 3'h0;
        end else if (!top_reg.sync_prev) begin
            top_next.rel_cnt = SPD_SYNC_CYCLES;
        end else if (top_reg.rel_cnt != 3'h0) begin
            top_next.rel_cnt = top_reg.rel_cnt - 3'h1;
        end
        // start is a flop so all three dividers leave hold on one edge
        top_next.start = top_reg.sync_stab && (top_reg.rel_cnt == 3'h1);

        // status follows the live decode; only divider ratio and phase wait for a sync
        for (int i = 0; i < SPD_NUM_OUTS; i++) begin
            top_next.enable[i] = cfg[i].enable;
            top_next.bypass[i] = cfg[i].bypass;
        end
        // word and range only pass through; the analog delay sits outside
        top_next.fine_on     = (mode_lvl != SPD_LVL_0);
        top_next.fine_word   = (mode_lvl != SPD_LVL_0) ? idx_34 : 4'h0;
        top_next.delay_range = mode_lvl;
        top_next.level_sel   = top_reg.pin_stab[1];
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            // reset acts as the power-on sync: count down as if just released
            top_reg.pin_meta    <= '0;
            top_reg.pin_stab    <= '0;
            top_reg.sync_meta   <= 1'b1;
            top_reg.sync_stab   <= 1'b1;
            top_reg.sync_prev   <= 1'b1;
            top_reg.rel_cnt     <= SPD_SYNC_CYCLES;
            top_reg.start       <= 1'b0;
            top_reg.enable      <= '0;
            top_reg.bypass      <= '0;
            top_reg.fine_word   <= 4'h0;
            top_reg.fine_on     <= 1'b0;
            top_reg.delay_range <= 2'h0;
            top_reg.level_sel   <= 2'h0;
        end else begin
            top_reg <= top_next;
        end
    end

    // ****************************************
    // dividers
    // ****************************************
    for (genvar g = 0; g < SPD_NUM_OUTS; g++) begin : g_div
        // hold comes from the second sync flop, so all three freeze on one edge
        spd_divider u_div (
            .clk   (CLK),
            .rst   (SYS_RST),
            .cfg   (cfg[g]),
            .hold  (!top_reg.sync_stab),
            .start (top_reg.start),
            .out   (div_out[g])
        );
    end

    // ****************************************
    // outputs
    // ****************************************
    assign CLOCK_OUTPUT_A   = div_out[0];
    assign CLOCK_OUTPUT_B   = div_out[1];
    assign CLOCK_OUTPUT_C   = div_out[2];
    assign OUTPUT_ENABLE    = top_reg.enable;
    assign OUTPUT_BYPASS    = top_reg.bypass;
    assign FINE_DELAY_WORD  = top_reg.fine_word;
    assign FINE_DELAY_ON    = top_reg.fine_on;
    assign DELAY_RANGE      = top_reg.delay_range;
    assign OUTPUT_LEVEL_SEL = top_reg.level_sel;

endmodule : spd_top

// ===== test/spd_asserts.sv
/* checker for spd_top, bound to its ports.
   assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
module spd_asserts (
    // clock and reset
    input wire logic       CLK,
    input wire logic       SYS_RST,
    // inputs
    input wire logic [1:0] DELAY_MODE_PIN,
    input wire logic [1:0] OUTPUT_LEVEL_PIN,
    input wire logic [1:0] OUTPUT_USE_PIN,
    input wire logic [1:0] FINE_WORD_LOW_PIN,
    input wire logic [1:0] FINE_WORD_HIGH_PIN,
    input wire logic       SYNC_REQUEST_N,
    // outputs
    input wire logic       CLOCK_OUTPUT_A,
    input wire logic       CLOCK_OUTPUT_B,
    input wire logic       CLOCK_OUTPUT_C,
    input wire logic [2:0] OUTPUT_ENABLE,
    input wire logic [2:0] OUTPUT_BYPASS,
    input wire logic [3:0] FINE_DELAY_WORD,
    input wire logic       FINE_DELAY_ON,
    input wire logic [1:0] DELAY_RANGE,
    input wire logic [1:0] OUTPUT_LEVEL_SEL
);
    import spd_pkg::*;
    // $past depth 3 must never reach back into reset
    logic [2:0] up_reg;
    logic       ok;
    always_ff @(posedge CLK) begin
        up_reg <= SYS_RST ? 3'h0 : (up_reg == 3'h7) ? up_reg : up_reg + 3'h1;
    end
    assign ok = (up_reg == 3'h7);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    chk_fine_on_flag: assert property (ok |-> FINE_DELAY_ON == ($past(DELAY_MODE_PIN, 3) != SPD_LVL_0))
        else $error("fine delay flag wrong");
    chk_delay_range: assert property (ok |-> DELAY_RANGE == $past(DELAY_MODE_PIN, 3))
        else $error("delay range wrong");
    chk_fine_word: assert property (ok |-> FINE_DELAY_WORD == (($past(DELAY_MODE_PIN, 3) != SPD_LVL_0) ?
        {$past(FINE_WORD_HIGH_PIN, 3), $past(FINE_WORD_LOW_PIN, 3)} : 4'h0))
        else $error("fine delay word wrong");
    chk_enable_decode: assert property (ok |-> OUTPUT_ENABLE == {$past(OUTPUT_USE_PIN, 3) != SPD_LVL_0,
        $past(OUTPUT_USE_PIN, 3) != SPD_LVL_1, $past(OUTPUT_USE_PIN, 3) != SPD_LVL_2_3})
        else $error("output enables wrong");
    chk_off_low: assert property (ok && !OUTPUT_ENABLE[0] && !$past(OUTPUT_ENABLE[0]) |-> !CLOCK_OUTPUT_A)
        else $error("disabled output not low");
    chk_bypass_high: assert property (ok && (&{OUTPUT_ENABLE[0], OUTPUT_BYPASS[0]}) &&
        $past(OUTPUT_ENABLE[0] && OUTPUT_BYPASS[0]) |-> CLOCK_OUTPUT_A)
        else $error("bypassed output not passing clock");
    chk_sync_freeze: assert property (ok ##0 (!SYNC_REQUEST_N)[*6] ##0 !OUTPUT_BYPASS[1] |-> !CLOCK_OUTPUT_B)
        else $error("output not frozen during sync");
    chk_release_wait: assert property (ok && $rose(SYNC_REQUEST_N) && !CLOCK_OUTPUT_B && !OUTPUT_BYPASS[1]
        |=> (!CLOCK_OUTPUT_B)[*6])
        else $error("output resumed too early");
    chk_level_pass: assert property (ok |-> OUTPUT_LEVEL_SEL == $past(OUTPUT_LEVEL_PIN, 3))
        else $error("output level select wrong");
    chk_third_off_low: assert property (ok && !OUTPUT_ENABLE[2] |-> !CLOCK_OUTPUT_C)
        else $error("disabled third output not low");
endmodule : spd_asserts

bind spd_top spd_asserts u_chk (.CLK(CLK), .SYS_RST(SYS_RST), .DELAY_MODE_PIN(DELAY_MODE_PIN),
    .OUTPUT_LEVEL_PIN(OUTPUT_LEVEL_PIN), .OUTPUT_USE_PIN(OUTPUT_USE_PIN),
    .FINE_WORD_LOW_PIN(FINE_WORD_LOW_PIN), .FINE_WORD_HIGH_PIN(FINE_WORD_HIGH_PIN),
    .SYNC_REQUEST_N(SYNC_REQUEST_N), .CLOCK_OUTPUT_A(CLOCK_OUTPUT_A), .CLOCK_OUTPUT_B(CLOCK_OUTPUT_B),
    .CLOCK_OUTPUT_C(CLOCK_OUTPUT_C), .OUTPUT_ENABLE(OUTPUT_ENABLE), .OUTPUT_BYPASS(OUTPUT_BYPASS),
    .FINE_DELAY_WORD(FINE_DELAY_WORD), .FINE_DELAY_ON(FINE_DELAY_ON), .DELAY_RANGE(DELAY_RANGE),
    .OUTPUT_LEVEL_SEL(OUTPUT_LEVEL_SEL));

// ===== test/spd_strap_model.sv
/* board strap network: eleven static four-level pins.
   assumes the bench changes the strap word only between syncs. */
`timescale 1ns/1ps
module spd_strap_model (
    // requested strap levels, pin i at element i
    input  wire logic [10:0][1:0] strap,
    // pin levels seen by the block
    output logic      [10:0][1:0] pins
);
    import spd_pkg::*;
    // straps are wires to rails, so no float state is modelled
    always_comb pins = strap;
endmodule : spd_strap_model

// ===== test/spd_top_tb.sv
/* self-checking bench for spd_top: straps, sync pulses, edge timing.
   assumes notes are pushed only after a sync release. */
`timescale 1ns/1ps
module spd_top_tb;
    import spd_pkg::*;
    typedef struct packed { logic [31:0] rise; logic [31:0] high; } spd_note_t;
    logic             clk = 1'b0;
    logic             sys_rst = 1'b1;
    logic             sync_request_n = 1'b1;
    logic [10:0][1:0] strap = '0;
    logic [10:0][1:0] pins;
    logic [2:0]       clk_out;
    logic [2:0]       en;
    logic [2:0]       byp;
    logic [2:0]       last_out = '0;
    logic [31:0]      cyc = '0;
    logic [31:0]      rise_at [3];
    spd_note_t        nt;
    spd_note_t        q [3][$];
    int               num_errors = 0;
    int               n_compared = 0;

    spd_strap_model u_strap (.strap(strap), .pins(pins));
    spd_top u_dut (.CLK(clk), .SYS_RST(sys_rst), .DELAY_MODE_PIN(pins[0]), .OUTPUT_LEVEL_PIN(pins[1]),
        .OUTPUT_USE_PIN(pins[2]), .FINE_WORD_LOW_PIN(pins[3]), .FINE_WORD_HIGH_PIN(pins[4]),
        .SECOND_DIV_LOW_PIN(pins[5]), .SECOND_DIV_HIGH_PIN(pins[6]), .THIRD_DIV_LOW_PIN(pins[7]),
        .THIRD_DIV_HIGH_PIN(pins[8]), .FIRST_DIV_LOW_PIN(pins[9]), .FIRST_DIV_HIGH_PIN(pins[10]),
        .SYNC_REQUEST_N(sync_request_n), .CLOCK_OUTPUT_A(clk_out[0]), .CLOCK_OUTPUT_B(clk_out[1]),
        .CLOCK_OUTPUT_C(clk_out[2]), .OUTPUT_ENABLE(en), .OUTPUT_BYPASS(byp), .FINE_DELAY_WORD(),
        .FINE_DELAY_ON(), .DELAY_RANGE(), .OUTPUT_LEVEL_SEL());

    always #10 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 32'h1;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic end_of_test();
        $display("errors=%0d compared=%0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_of_test

    // sampled on the falling edge so registered outputs have settled
    always @(negedge clk) begin
        for (int i = 0; i < 3; i++) begin
            if (clk_out[i] === 1'b1 && !last_out[i]) rise_at[i] = cyc;
            if (clk_out[i] === 1'b0 && last_out[i] && q[i].size() > 0) begin
                nt = q[i].pop_front();
                check(rise_at[i], nt.rise);
                check(cyc - rise_at[i], nt.high);
            end
        end
        last_out = clk_out;
    end

    // expected ratios come from the package tables, index = low + 4 * high; offsets come straight from the pin pairs
    task automatic run_case(input logic [10:0][1:0] s);
        logic [5:0]  r [3];
        logic [3:0]  p [3];
        logic [31:0] base;
        r[0] = (s[2] == SPD_LVL_2_3) ? 6'h00 : SPD_STD_RATIO[{s[10], s[9]}];
        r[1] = (s[2] == SPD_LVL_1) ? 6'h00 : SPD_STD_RATIO[{s[8], s[7]}];
        r[2] = (s[2] == SPD_LVL_0) ? 6'h00 : (s[2] == SPD_LVL_2_3) ? SPD_ALT_RATIO[{s[10], s[9]}] :
            SPD_STD_RATIO[{s[6], s[5]}];
        p[0] = 4'h0;
        p[1] = (s[2] == SPD_LVL_0) ? {s[6], s[5]} : 4'h0;
        p[2] = (s[0] == SPD_LVL_0) ? {s[4], s[3]} : (s[2] == SPD_LVL_1) ? {s[8], s[7]} : 4'h0;
        @(posedge clk);
        #1 strap = s;
        // settings change while running; ratio and phase only count after the sync below
        repeat (8) @(posedge clk);
        #1 sync_request_n = 1'b0;
        repeat (10) @(posedge clk);
        #1 sync_request_n = 1'b1;
        base = cyc;
        // first rise 9 edges on: 2 sync flops, 5 to the start pulse, 2 into the run state
        for (int k = 0; k < 3; k++) begin
            for (int j = 0; j < 3 && r[k] > 6'h01; j++) begin
                q[k].push_back('{base + 32'h9 + 32'(p[k] % r[k]) + 32'(j) * 32'(r[k]), 32'(r[k] / 6'h2)});
            end
        end
        for (int w = 0; w < 200 && q[0].size() + q[1].size() + q[2].size() > 0; w++) @(posedge clk);
        check(32'(q[0].size() + q[1].size() + q[2].size()), 32'h0);
        #1;
        check(32'(en), 32'({s[2] != SPD_LVL_0, s[2] != SPD_LVL_1, s[2] != SPD_LVL_2_3}));
        // a disabled output parks at ratio one, so it reads as bypassed too
        check(32'(byp), 32'({r[2] < 6'h02, r[1] < 6'h02, r[0] < 6'h02}));
        for (int k = 0; k < 3; k++) begin
            if (r[k] < 6'h02) check(32'(clk_out[k]), 32'(r[k]));
        end
    endtask : run_case

    initial begin
        logic [10:0][1:0] s;
        void'($urandom(83068));
        repeat (6) @(posedge clk);
        #1 sys_rst = 1'b0;
        repeat (12) @(posedge clk);
        run_case({2'h0, 2'h0, 2'h0, 2'h3, 2'h1, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0});
        run_case({2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h1, 2'h3, 2'h0});
        for (int n = 0; n < 14; n++) begin
            s = 22'($urandom);
            if (n < 4) s[2] = n[1:0];
            run_case(s);
        end
        end_of_test();
    end

    initial begin
        repeat (10000) @(posedge clk);
        num_errors++;
        end_of_test();
    end
endmodule : spd_top_tb
